// ==== include/dco_pkg.sv ====
package dco_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] AMP_REG_OFFSET = 8'h05;
  localparam logic [7:0] OE_REG_A_OFFSET = 8'h01;
  localparam logic [7:0] OE_REG_B_OFFSET = 8'h02;
  localparam logic [7:0] AMP_REG_RESET = 8'h00;
  localparam logic [7:0] OE_REG_A_RESET = 8'h17;
  localparam logic [7:0] OE_REG_B_RESET = 8'hf8;
  localparam int AMP_SEL_BIT = 7;
  localparam int AMP_CODE_LSB = 4;
  localparam int AMP_CODE_MSB = 6;
  localparam int OE_A_BIT0 = 4;
  localparam int OE_A_BIT1 = 2;
  localparam int OE_A_BIT2 = 1;
  localparam int OE_A_BIT3 = 0;
  localparam int OE_B_BIT4 = 7;
  localparam int OE_B_BIT8 = 3;

  // ---------------------------------------------------------------
  // Amplitude and clock constants
  // ---------------------------------------------------------------
  localparam logic [10:0] AMP_BASE_MV = 11'h12c;
  localparam logic [10:0] AMP_STEP_MV = 11'h064;
  localparam logic [10:0] AMP_DEFAULT_MV = 11'h2bc;
  localparam int NUM_OUTPUTS = 9;
  localparam int OUT_FREQ_MHZ = 100;
  localparam int CLK_FREQ_MHZ = 200;
  localparam int OUT_HALF_CYCLES = CLK_FREQ_MHZ / (2 * OUT_FREQ_MHZ);

endpackage : dco_pkg

// ==== verilog/dco_top.sv ====
`timescale 1ns/1ps
// Functional notes
// - Override bit clear: outputs use default amplitude, code ignored.
// - Override bit set: swing comes from the three-bit code field.
// - Code maps linearly: 300 mV plus 100 mV per step.
// - Outputs zero to three each have their own disable pin.
// - One shared disable pin gates outputs four and five.
// - One shared disable pin gates outputs six, seven and eight.
// - Spread pin high sets spread_active only; the output clocks are not modulated.
// - Nine outputs, each a 100 MHz clock when enabled.
// - Each output has a register enable bit, one enables.
// - Host reaches registers over a parallel bus: write strobe, 8-bit address and data.
// - All control registers load defaults at reset.
module dco_top (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic output_gate_pin_0,
  input wire logic output_gate_pin_1,
  input wire logic output_gate_pin_2,
  input wire logic output_gate_pin_3,
  input wire logic output_gate_pin_45,
  input wire logic output_gate_pin_68,
  input wire logic spread_request_pin,
  output logic [8:0] ref_clock_out,
  output logic [8:0] out_active,
  output logic spread_active,
  output logic [10:0] swing_mv
);

  // ---------------------------------------------------------------
  // Reset release and pin synchronisers
  // ---------------------------------------------------------------
  logic [1:0] rst_sync;
  logic nrst_int;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign nrst_int = rst_sync[1];

  logic [6:0] pin_raw;
  assign pin_raw = {spread_request_pin, output_gate_pin_68,
    output_gate_pin_45, output_gate_pin_3, output_gate_pin_2,
    output_gate_pin_1, output_gate_pin_0};

  typedef struct packed {
    logic [6:0] pin_s1;
    logic [6:0] pin_s2;
    logic [7:0] amp_r;
    logic [7:0] oe_a_r;
    logic [7:0] oe_b_r;
    logic phase;
    logic [7:0] rdata;
    logic [8:0] clk_out;
    logic [8:0] act;
    logic spread;
    logic [10:0] swing;
  } dco_state_t;

  dco_state_t st_r;
  dco_state_t st_nxt;
  logic [8:0] pin_en;
  logic [8:0] reg_en;
  logic [8:0] en;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.pin_s1 = pin_raw;
    st_nxt.pin_s2 = st_r.pin_s1;
    if (reg_wr) begin
      case (reg_addr)
        dco_pkg::AMP_REG_OFFSET: st_nxt.amp_r = reg_wdata;
        dco_pkg::OE_REG_A_OFFSET: st_nxt.oe_a_r = reg_wdata;
        dco_pkg::OE_REG_B_OFFSET: st_nxt.oe_b_r = reg_wdata;
        default: st_nxt.amp_r = st_r.amp_r;
      endcase
    end
    case (reg_addr)
      dco_pkg::AMP_REG_OFFSET: st_nxt.rdata = st_r.amp_r;
      dco_pkg::OE_REG_A_OFFSET: st_nxt.rdata = st_r.oe_a_r;
      dco_pkg::OE_REG_B_OFFSET: st_nxt.rdata = st_r.oe_b_r;
      default: st_nxt.rdata = 8'h00;
    endcase
    pin_en = {{3{st_r.pin_s2[5]}}, {2{st_r.pin_s2[4]}},
      st_r.pin_s2[3:0]};
    // Enable bits sit in the opposite order to the outputs they gate,
    // so each one is picked singly rather than as a slice.
    reg_en = {st_r.oe_b_r[dco_pkg::OE_B_BIT8],
      st_r.oe_b_r[dco_pkg::OE_B_BIT8 + 1],
      st_r.oe_b_r[dco_pkg::OE_B_BIT8 + 2],
      st_r.oe_b_r[dco_pkg::OE_B_BIT4 - 1],
      st_r.oe_b_r[dco_pkg::OE_B_BIT4],
      st_r.oe_a_r[dco_pkg::OE_A_BIT3], st_r.oe_a_r[dco_pkg::OE_A_BIT2],
      st_r.oe_a_r[dco_pkg::OE_A_BIT1], st_r.oe_a_r[dco_pkg::OE_A_BIT0]};
    en = pin_en & reg_en;
    st_nxt.act = en;
    // Clock divides by two from 200 MHz; disabled outputs park low.
    st_nxt.phase = ~st_r.phase;
    st_nxt.clk_out = en & {9{st_nxt.phase}};
    st_nxt.spread = st_r.pin_s2[6];
    if (st_r.amp_r[dco_pkg::AMP_SEL_BIT]) begin
      st_nxt.swing = dco_pkg::AMP_BASE_MV + 11'(dco_pkg::AMP_STEP_MV *
        11'(st_r.amp_r[dco_pkg::AMP_CODE_MSB:dco_pkg::AMP_CODE_LSB]));
    end else begin
      st_nxt.swing = dco_pkg::AMP_DEFAULT_MV;
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge nrst_int) begin
    if (!nrst_int) begin
      st_r <= '0;
      st_r.pin_s1 <= 7'h3f;
      st_r.pin_s2 <= 7'h3f;
      st_r.amp_r <= dco_pkg::AMP_REG_RESET;
      st_r.oe_a_r <= dco_pkg::OE_REG_A_RESET;
      st_r.oe_b_r <= dco_pkg::OE_REG_B_RESET;
      st_r.swing <= dco_pkg::AMP_DEFAULT_MV;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata = st_r.rdata;
  assign ref_clock_out = st_r.clk_out;
  assign out_active = st_r.act;
  assign spread_active = st_r.spread;
  assign swing_mv = st_r.swing;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_default_amp;
    @(posedge clk) disable iff (!nrst_int)
    !st_r.amp_r[7] |=> swing_mv == 11'h2bc;
  endproperty
  a_default_amp: assert property (p_default_amp)
    else $error("default amplitude not applied");

  property p_code_amp;
    @(posedge clk) disable iff (!nrst_int)
    st_r.amp_r[7] |=> swing_mv == 11'd300 + 11'd100 *
      11'($past(st_r.amp_r[6:4]));
  endproperty
  a_code_amp: assert property (p_code_amp)
    else $error("coded amplitude wrong");

  property p_max_amp;
    @(posedge clk) disable iff (!nrst_int)
    st_r.amp_r[7:4] == 4'hf |=> swing_mv == 11'd1000;
  endproperty
  a_max_amp: assert property (p_max_amp)
    else $error("code seven not 1000 mV");

  property p_pin0_off;
    @(posedge clk) disable iff (!nrst_int)
    !output_gate_pin_0 [*3] |=> !ref_clock_out[0] && !out_active[0];
  endproperty
  a_pin0_off: assert property (p_pin0_off)
    else $error("output zero not gated by its pin");

  property p_group45;
    @(posedge clk) disable iff (!nrst_int)
    !output_gate_pin_45 [*3] |=> out_active[5:4] == 2'h0;
  endproperty
  a_group45: assert property (p_group45)
    else $error("outputs four and five not gated");

  property p_group68;
    @(posedge clk) disable iff (!nrst_int)
    !output_gate_pin_68 [*3] |=> out_active[8:6] == 3'h0;
  endproperty
  a_group68: assert property (p_group68)
    else $error("outputs six to eight not gated");

  property p_spread;
    @(posedge clk) disable iff (!nrst_int)
    spread_request_pin [*3] |=> spread_active;
  endproperty
  a_spread: assert property (p_spread)
    else $error("spread not applied");

  property p_toggle;
    @(posedge clk) disable iff (!nrst_int)
    out_active[3] && $past(out_active[3]) |->
      ref_clock_out[3] != $past(ref_clock_out[3]);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("enabled output not toggling");

  property p_regen;
    @(posedge clk) disable iff (!nrst_int)
    !st_r.oe_b_r[7] |=> !out_active[4];
  endproperty
  a_regen: assert property (p_regen)
    else $error("register enable ignored");

  property p_readback;
    @(posedge clk) disable iff (!nrst_int)
    reg_wr && reg_addr == 8'h05 ##1 reg_addr == 8'h05 && !reg_wr |=>
      reg_rdata == $past(reg_wdata, 2);
  endproperty
  a_readback: assert property (p_readback)
    else $error("amplitude register readback wrong");

  c_override: cover property (@(posedge clk) st_r.amp_r[7]);
  c_spread: cover property (@(posedge clk) spread_active);
  c_all_on: cover property (@(posedge clk) out_active == 9'h1ff);
  c_gated: cover property (@(posedge clk) out_active == 9'h000);

endmodule : dco_top

// ==== dv/dco_load_model.sv ====
`timescale 1ns/1ps
// Clock load: flags each output that changed level since the last edge.
module dco_load_model (
  input wire logic clk,
  input wire logic [8:0] ref_clock_out,
  output logic [8:0] toggled
);
  logic [8:0] last_r;
  always_ff @(posedge clk) begin
    toggled <= ref_clock_out ^ last_r;
    last_r <= ref_clock_out;
  end
endmodule : dco_load_model

// ==== dv/dco_top_bench.sv ====
`timescale 1ns/1ps
module dco_top_bench;
  logic clk, nrst, reg_wr, spr, spa;
  logic [5:0] pin;
  logic [7:0] addr, wdata, rdata;
  logic [8:0] rco, act, tog;
  logic [10:0] swing;
  int n_errors, samples_checked, cyc;
  logic [8:0] m [6] = '{9'h001, 9'h002, 9'h004, 9'h008, 9'h030, 9'h1c0};
  // ---------------------------------------------------------------
  // Clock, design and load
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  dco_top DUT (.clk(clk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .output_gate_pin_0(pin[0]),
    .output_gate_pin_1(pin[1]), .output_gate_pin_2(pin[2]),
    .output_gate_pin_3(pin[3]), .output_gate_pin_45(pin[4]),
    .output_gate_pin_68(pin[5]), .spread_request_pin(spr),
    .ref_clock_out(rco), .out_active(act), .spread_active(spa),
    .swing_mv(swing));
  dco_load_model load (.clk(clk), .ref_clock_out(rco), .toggled(tog));
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task chk(input string what, input logic [10:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task wr(input logic [7:0] a, d);
    @(negedge clk);
    reg_wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
    repeat (4) @(negedge clk);
  endtask : wr
  task rd(input logic [7:0] a, exp);
    @(negedge clk);
    addr = a;
    @(negedge clk);
    chk("rdata", {3'h0, rdata}, {3'h0, exp});
  endtask : rd
  // Pin changes pass a two-flop synchroniser, so allow settling time.
  task pins(input logic [5:0] p, input logic [8:0] exp);
    pin = p;
    repeat (6) @(negedge clk);
    chk("active", {2'h0, act}, {2'h0, exp});
    chk("toggled", {2'h0, tog}, {2'h0, exp});
  endtask : pins
  task results;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      results;
    end
  end
  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    reg_wr = 1'b0;
    spr = 1'b0;
    pin = 6'h3f;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("swing", swing, 11'h2bc);
    rd(8'h05, 8'h00);
    rd(8'h01, 8'h17);
    rd(8'h02, 8'hf8);
    rd(8'h00, 8'h00);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'h00);
    pins(6'h3f, 9'h1ff);
    chk("spread", {10'h0, spa}, 11'h000);
    for (int i = 0; i < 8; i++) begin
      wr(8'h05, {1'b1, 3'(i), 4'ha});
      chk("swing", swing, 11'(300 + 100 * i));
      rd(8'h05, {1'b1, 3'(i), 4'ha});
    end
    wr(8'h05, 8'h75);
    chk("swing", swing, 11'h2bc);
    for (int i = 0; i < 6; i++) begin
      pins(~(6'h01 << i), ~m[i]);
    end
    pins(6'h3f, 9'h1ff);
    wr(8'h01, 8'h14);
    chk("active", {2'h0, act}, 11'h1f3);
    wr(8'h01, 8'h02);
    chk("active", {2'h0, act}, 11'h1f4);
    wr(8'h01, 8'h01);
    chk("active", {2'h0, act}, 11'h1f8);
    wr(8'h01, 8'h00);
    chk("active", {2'h0, act}, 11'h1f0);
    wr(8'h02, 8'hc0);
    chk("active", {2'h0, act}, 11'h030);
    wr(8'h02, 8'h08);
    chk("active", {2'h0, act}, 11'h100);
    wr(8'h02, 8'h00);
    chk("active", {2'h0, act}, 11'h000);
    spr = 1'b1;
    repeat (6) @(negedge clk);
    chk("spread", {10'h0, spa}, 11'h001);
    results;
  end
endmodule : dco_top_bench
